/* File: sad_bus_master_model.sv */
`timescale 1ns/1ps
module sad_bus_master_model (
  // Clock
  input  wire logic        i_core_clk,
  // Code bus master
  output logic             o_cb_req,
  output logic [31:0]      o_cb_addr,
  output logic             o_cb_write,
  output logic             o_cb_fetch,
  // Data bus master
  output logic             o_db_req,
  output logic [31:0]      o_db_addr,
  output logic             o_db_write,
  // DSP master
  output logic             o_dsp_req,
  output logic [31:0]      o_dsp_addr,
  output logic             o_dsp_write
);
  logic [2:0]  pend_r;
  logic [31:0] pa_r [3];
  logic [2:0]  pw_r;
  logic        pf_r;

  // Queue one word access for the next cycle
  task automatic post(input int m, input logic [31:0] a, input logic w,
                      input logic f);
    pend_r[m] = 1'b1;
    pa_r[m] = a;
    pw_r[m] = w;
    if (m == 0)
      pf_r = f;
  endtask

  initial
  begin
    pend_r = 3'h0;
    pf_r = 1'b0;
    {o_cb_req, o_db_req, o_dsp_req} = 3'h0;
    {o_cb_write, o_cb_fetch, o_db_write, o_dsp_write} = 4'h0;
    {o_cb_addr, o_db_addr, o_dsp_addr} = {3{32'h0000_0000}};
  end

  // Idle cycles invert the qualifiers every cycle, never hold the last request
  always @(negedge i_core_clk)
  begin
    o_cb_req    <= pend_r[0];
    o_cb_addr   <= pend_r[0] ? pa_r[0] : ~o_cb_addr;
    o_cb_write  <= pend_r[0] ? pw_r[0] : ~o_cb_write;
    o_cb_fetch  <= pend_r[0] ? pf_r : ~o_cb_fetch;
    o_db_req    <= pend_r[1];
    o_db_addr   <= pend_r[1] ? pa_r[1] : ~o_db_addr;
    o_db_write  <= pend_r[1] ? pw_r[1] : ~o_db_write;
    o_dsp_req   <= pend_r[2];
    o_dsp_addr  <= pend_r[2] ? pa_r[2] : ~o_dsp_addr;
    o_dsp_write <= pend_r[2] ? pw_r[2] : ~o_dsp_write;
    pend_r = 3'h0;
  end
endmodule

/* File: sad_decoder.sv */
`timescale 1ns/1ps
module sad_decoder (
  // Clock and reset
  input  wire logic         i_core_clk,
  input  wire logic         i_resetn,
  // CPU code bus request
  input  wire logic         i_cb_req,
  input  wire logic [31:0]  i_cb_addr,
  input  wire logic         i_cb_write,
  input  wire logic         i_cb_fetch,
  // CPU data bus request
  input  wire logic         i_db_req,
  input  wire logic [31:0]  i_db_addr,
  input  wire logic         i_db_write,
  // DSP request
  input  wire logic         i_dsp_req,
  input  wire logic [31:0]  i_dsp_addr,
  input  wire logic         i_dsp_write,
  // Port checker range tables, 64 bits per port
  input  wire logic [1023:0] i_chk_rules,
  // Protection unit setup
  input  wire logic         i_mpu_enable,
  input  wire logic [7:0]   i_mpu_rgn_en,
  input  wire logic [255:0] i_mpu_base,
  input  wire logic [39:0]  i_mpu_size,
  input  wire logic [63:0]  i_mpu_sub_dis,
  input  wire logic [7:0]   i_mpu_ro,
  // Code bus answer
  output logic              o_cb_done,
  output logic              o_cb_stall,
  output logic              o_cb_buserr,
  output logic              o_cb_mmfault,
  output logic [3:0]        o_cb_port,
  output logic              o_cb_secure,
  // Data bus answer
  output logic              o_db_done,
  output logic              o_db_stall,
  output logic              o_db_buserr,
  output logic              o_db_mmfault,
  output logic [3:0]        o_db_port,
  output logic              o_db_secure,
  output logic [5:0]        o_db_slot,
  // DSP answer
  output logic              o_dsp_done,
  output logic              o_dsp_stall,
  output logic              o_dsp_buserr,
  output logic [3:0]        o_dsp_port
);

  localparam int NM = sad_pkg::NMST;
  localparam int RW = $clog2(sad_pkg::NRANGE);

  logic [NM-1:0]      req_w;
  logic [NM-1:0]      wr_w;
  logic [NM-1:0]      fetch_w;
  logic [31:0]        addr_w [NM];

  sad_pkg::sad_port_t port_c [NM];
  logic [RW-1:0]      range_c [NM];
  logic [sad_pkg::RULE_W-1:0] rules_c [NM];
  logic [NM-1:0]      sec_c;
  logic [NM-1:0]      chk_c;
  logic [NM-1:0]      allow_c;
  logic [NM-1:0]      mmf_c;
  logic [NM-1:0]      unm_c;
  logic [NM-1:0]      ok_c;
  logic [NM-1:0]      stall_c;

  logic [NM-1:0]      done_r;
  logic [NM-1:0]      stall_r;
  logic [NM-1:0]      buserr_r;
  logic [NM-1:0]      mmf_r;
  logic [NM-1:0]      sec_r;
  sad_pkg::sad_port_t port_r [NM];
  logic [5:0]         slot_r;
  sad_pkg::sad_port_t alt_port_r;

  assign req_w   = {i_dsp_req, i_db_req, i_cb_req};
  assign wr_w    = {i_dsp_write, i_db_write, i_cb_write};
  assign fetch_w = {1'b0, 1'b0, i_cb_fetch};
  assign addr_w[sad_pkg::M_CB]  = i_cb_addr;
  assign addr_w[sad_pkg::M_DB]  = i_db_addr;
  assign addr_w[sad_pkg::M_DSP] = i_dsp_addr;

  // Shared RAM offset to matrix slave port
  function automatic sad_pkg::sad_port_t ram_part(input logic [31:0] off);
    sad_pkg::sad_port_t p;
    if (off < sad_pkg::RAM_P1)
      p = sad_pkg::SAD_P_RAM0;
    else if (off < sad_pkg::RAM_P2)
      p = sad_pkg::SAD_P_RAM1;
    else if (off < sad_pkg::RAM_P3)
      p = sad_pkg::SAD_P_RAM2;
    else if (off < sad_pkg::RAM_P4)
      p = sad_pkg::SAD_P_RAM3;
    else if (off < sad_pkg::RAM_P5)
      p = sad_pkg::SAD_P_RAM4;
    else
      p = sad_pkg::SAD_P_RAM5;
    return p;
  endfunction

  // Address to slave port for one master
  function automatic sad_pkg::sad_port_t dec(input logic [31:0] addr,
                                             input int m);
    logic [31:0]        a;
    logic [31:0]        off;
    logic               dsp;
    sad_pkg::sad_port_t p;
    dsp = (m == sad_pkg::M_DSP);
    // Bit 28 is an attribute only, the DSP has no alias
    a   = dsp ? addr : (addr & ~sad_pkg::SEC_BIT_MASK);
    off = a & sad_pkg::NIB_OFF_MASK;
    p   = sad_pkg::SAD_P_NONE;
    if (a[31:28] == sad_pkg::CODE_NIB && m != sad_pkg::M_DB)
    begin
      if (off < sad_pkg::RAM_SIZE)
        p = dsp ? sad_pkg::SAD_P_DRAM : ram_part(off);
      else if (!dsp && (a & sad_pkg::ROM_MASK) == sad_pkg::ROM_BASE)
        p = sad_pkg::SAD_P_ROM;
      else if ((a & sad_pkg::FLASH_MASK) == sad_pkg::FLASH_BASE)
        p = sad_pkg::SAD_P_FLASH;
    end
    else if (a[31:28] == sad_pkg::DATA_NIB && m != sad_pkg::M_CB)
    begin
      if (off < sad_pkg::RAM_SIZE)
        p = dsp ? sad_pkg::SAD_P_DRAM : ram_part(off);
      else if (!dsp && ((a & sad_pkg::TCM_MASK) == sad_pkg::TCMD_BASE ||
                        (a & sad_pkg::TCM_MASK) == sad_pkg::TCMI_BASE))
        p = sad_pkg::SAD_P_TCM;
      else if (dsp && (a & sad_pkg::FLASH_MASK) == sad_pkg::DFL_BASE)
        p = sad_pkg::SAD_P_FLASH;
    end
    else if (a[31:28] == sad_pkg::PERI_NIB && m != sad_pkg::M_CB)
    begin
      if ((a & sad_pkg::APB_MASK) == sad_pkg::APB_BASE)
        p = ((a & sad_pkg::APB_HOLE) == 32'h0000_0000) ?
            sad_pkg::SAD_P_APB : sad_pkg::SAD_P_NONE;
      else if (a >= sad_pkg::AHB_BASE && a < sad_pkg::AHB_END)
        p = sad_pkg::SAD_P_AHB;
    end
    return p;
  endfunction

  // Protection unit lookup, high means the access faults
  function automatic logic mpu_fault(input logic [31:0] a,
                                     input logic wr);
    logic        hit;
    logic        bad;
    logic [4:0]  sz;
    logic [2:0]  sub;
    logic [31:0] msk;
    logic [31:0] base;
    hit = 1'b0;
    bad = 1'b0;
    for (int r = 0; r < sad_pkg::MPU_NRGN; r++)
    begin
      sz = i_mpu_size[r*5 +: 5];
      if (sz < sad_pkg::MPU_MIN_LOG2)
        sz = sad_pkg::MPU_MIN_LOG2;
      msk  = 32'hFFFF_FFFF << sz;
      base = i_mpu_base[r*32 +: 32];
      sub  = 3'(a >> (sz - sad_pkg::MPU_SUB_BITS));
      if (i_mpu_rgn_en[r] && (a & msk) == (base & msk) &&
          !i_mpu_sub_dis[r*sad_pkg::MPU_NSUB + int'(sub)])
      begin
        hit = 1'b1;
        if (wr && i_mpu_ro[r])
          bad = 1'b1;
      end
    end
    return !hit || bad;
  endfunction

  // Decode every master in parallel
  always_comb
  begin
    for (int m = 0; m < NM; m++)
    begin
      port_c[m]  = dec(addr_w[m], m);
      sec_c[m]   = (m != sad_pkg::M_DSP) &&
                   addr_w[m][sad_pkg::SEC_BIT];
      range_c[m] = addr_w[m][sad_pkg::RANGE_LSB +: RW];
      rules_c[m] = i_chk_rules[32'(port_c[m]) * sad_pkg::RULE_W +:
                               sad_pkg::RULE_W];
      unm_c[m]   = (port_c[m] == sad_pkg::SAD_P_NONE);
      mmf_c[m]   = (m != sad_pkg::M_DSP) && i_mpu_enable &&
                   mpu_fault(addr_w[m], wr_w[m]);
    end
  end

  genvar g;
  generate
    for (g = 0; g < NM; g++)
    begin : g_chk
      sad_port_checker #(
        .NRANGE (sad_pkg::NRANGE)
      ) u_chk (
        .i_rules  (rules_c[g]),
        .i_range  (range_c[g]),
        .i_secure (sec_c[g]),
        .i_fetch  (fetch_w[g]),
        .o_allow  (chk_c[g])
      );
    end
  endgenerate

  // Direct DSP RAM path skips the checker
  always_comb
  begin
    for (int m = 0; m < NM; m++)
    begin
      allow_c[m] = (port_c[m] == sad_pkg::SAD_P_DRAM) | chk_c[m];
      ok_c[m]    = req_w[m] && !mmf_c[m] && !unm_c[m] && allow_c[m];
    end
  end

  // Fixed priority data bus, code bus, DSP on a shared slave port
  always_comb
  begin
    stall_c = '0;
    for (int m = 0; m < NM; m++)
    begin
      for (int k = 0; k < NM; k++)
      begin
        if (k != m && k != sad_pkg::M_DSP && m != sad_pkg::M_DB &&
            ok_c[k] && port_c[k] == port_c[m] &&
            port_c[m] != sad_pkg::SAD_P_DRAM)
          stall_c[m] = 1'b1;
      end
    end
  end

  // Answer flags
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      done_r   <= '0;
      stall_r  <= '0;
      buserr_r <= '0;
      mmf_r    <= '0;
    end
    else
    begin
      for (int m = 0; m < NM; m++)
      begin
        done_r[m]   <= (ok_c[m] && !stall_c[m]) ||
                       (m == sad_pkg::M_DSP && req_w[m] && unm_c[m]);
        stall_r[m]  <= ok_c[m] && stall_c[m];
        buserr_r[m] <= req_w[m] && !mmf_c[m] &&
                       ((unm_c[m] && m != sad_pkg::M_DSP) ||
                        (!unm_c[m] && !allow_c[m]));
        mmf_r[m]    <= req_w[m] && mmf_c[m];
      end
    end
  end

  // Selected port and attribute
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      for (int m = 0; m < NM; m++)
        port_r[m] <= sad_pkg::SAD_P_NONE;
      sec_r <= '0;
    end
    else
    begin
      for (int m = 0; m < NM; m++)
        port_r[m] <= req_w[m] ? port_c[m] : sad_pkg::SAD_P_NONE;
      sec_r <= req_w & sec_c;
    end
  end

  // APB slot index of the data bus
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      slot_r <= 6'h00;
    else if (i_db_req)
      slot_r <= i_db_addr[sad_pkg::APB_SLOT_LSB +: sad_pkg::APB_SLOT_W];
  end

  assign o_cb_done    = done_r[sad_pkg::M_CB];
  assign o_cb_stall   = stall_r[sad_pkg::M_CB];
  assign o_cb_buserr  = buserr_r[sad_pkg::M_CB];
  assign o_cb_mmfault = mmf_r[sad_pkg::M_CB];
  assign o_cb_port    = port_r[sad_pkg::M_CB];
  assign o_cb_secure  = sec_r[sad_pkg::M_CB];
  assign o_db_done    = done_r[sad_pkg::M_DB];
  assign o_db_stall   = stall_r[sad_pkg::M_DB];
  assign o_db_buserr  = buserr_r[sad_pkg::M_DB];
  assign o_db_mmfault = mmf_r[sad_pkg::M_DB];
  assign o_db_port    = port_r[sad_pkg::M_DB];
  assign o_db_secure  = sec_r[sad_pkg::M_DB];
  assign o_db_slot    = slot_r;
  assign o_dsp_done   = done_r[sad_pkg::M_DSP];
  assign o_dsp_stall  = stall_r[sad_pkg::M_DSP];
  assign o_dsp_buserr = buserr_r[sad_pkg::M_DSP];
  assign o_dsp_port   = port_r[sad_pkg::M_DSP];

  // Port of the other alias, for checking only
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      alt_port_r <= sad_pkg::SAD_P_NONE;
    else
      alt_port_r <= dec(i_cb_addr ^ sad_pkg::SEC_BIT_MASK, sad_pkg::M_CB);
  end

  default clocking dc @(posedge i_core_clk);
  endclocking
  default disable iff (!i_resetn);

  sequence db_ram_req;
    i_db_req && i_db_addr[31:29] == 3'h1 &&
    (i_db_addr & sad_pkg::NIB_OFF_MASK) < sad_pkg::RAM_SIZE;
  endsequence

  sequence db_apb_req;
    i_db_req && i_db_addr[31:29] == 3'h2 && i_db_addr[27:18] == 10'h000;
  endsequence

  sequence db_no_region;
    i_db_req && i_mpu_enable && i_mpu_rgn_en == 8'h00;
  endsequence

  secure_attr_a: assert property (
    i_cb_req |=> o_cb_secure == $past(i_cb_addr[28]))
    else $error("code bus attribute does not follow bit 28");

  alias_port_a: assert property (
    $past(i_cb_req) |-> o_cb_port == alt_port_r)
    else $error("aliases decode to different ports");

  ram_both_a: assert property (
    db_ram_req |=> o_db_port >= 4'h1 && o_db_port <= 4'h6)
    else $error("shared RAM missing on data bus");

  concurrent_a: assert property (
    o_cb_stall |-> o_db_done && o_cb_port == o_db_port)
    else $error("code bus stalled without contention");

  no_false_stall_a: assert property (
    (i_cb_req && i_db_req && !i_mpu_enable &&
     dec(i_cb_addr, 0) != dec(i_db_addr, 1)) |=> !o_cb_stall)
    else $error("different ports were serialised");

  cpu_unmapped_a: assert property (
    (o_db_port == 4'h0 && $past(i_db_req) && !o_db_mmfault)
      |-> o_db_buserr && !o_db_done)
    else $error("unmapped CPU access without bus error");

  dsp_unmapped_a: assert property (
    (o_dsp_port == 4'h0 && $past(i_dsp_req)) |-> o_dsp_done && !o_dsp_buserr)
    else $error("unmapped DSP access did not complete");

  apb_slot_a: assert property (
    db_apb_req |=> o_db_port == 4'hA && o_db_slot == $past(i_db_addr[17:12]))
    else $error("APB slot decode wrong");

  dsp_bypass_a: assert property (
    (i_dsp_req && (i_dsp_addr[31:28] == 4'h0 || i_dsp_addr[31:28] == 4'h2) &&
     (i_dsp_addr & sad_pkg::NIB_OFF_MASK) < sad_pkg::RAM_SIZE)
      |=> o_dsp_port == 4'hC && o_dsp_done && !o_dsp_buserr && !o_dsp_stall)
    else $error("DSP RAM access went through the matrix");

  mpu_fault_a: assert property (
    db_no_region |=> o_db_mmfault && !o_db_done && !o_db_buserr)
    else $error("access outside all regions not faulted");

  reject_err_a: assert property (
    (i_db_req && !mmf_c[1] && !unm_c[1] && !chk_c[1])
      |=> o_db_buserr && !o_db_done ##1 !o_db_buserr || $past(i_db_req))
    else $error("rejected request reached the slave");

endmodule

/* File: sad_pkg.sv */
package sad_pkg;

  // Bus masters seen by the decoder
  localparam int NMST  = 3;
  localparam int M_CB  = 0;
  localparam int M_DB  = 1;
  localparam int M_DSP = 2;

  // Security attribute bit of the address
  localparam int          SEC_BIT      = 28;
  localparam logic [31:0] SEC_BIT_MASK = 32'h1000_0000;
  localparam logic [31:0] NIB_OFF_MASK = 32'h0FFF_FFFF;

  // Top nibble of each bus region, attribute bit cleared
  localparam logic [3:0] CODE_NIB = 4'h0;
  localparam logic [3:0] DATA_NIB = 4'h2;
  localparam logic [3:0] PERI_NIB = 4'h4;

  // Shared RAM size and port partition boundaries
  localparam logic [31:0] RAM_SIZE   = 32'h0048_0000;
  localparam logic [31:0] RAM_P1     = 32'h0001_0000;
  localparam logic [31:0] RAM_P2     = 32'h0002_0000;
  localparam logic [31:0] RAM_P3     = 32'h0004_0000;
  localparam logic [31:0] RAM_P4     = 32'h0008_0000;
  localparam logic [31:0] RAM_P5     = 32'h0010_0000;

  // Other memory windows
  localparam logic [31:0] ROM_BASE   = 32'h0300_0000;
  localparam logic [31:0] ROM_MASK   = 32'hFFFC_0000;
  localparam logic [31:0] FLASH_BASE = 32'h0800_0000;
  localparam logic [31:0] DFL_BASE   = 32'h2800_0000;
  localparam logic [31:0] FLASH_MASK = 32'hF800_0000;
  localparam logic [31:0] TCMD_BASE  = 32'h2400_0000;
  localparam logic [31:0] TCMI_BASE  = 32'h2402_0000;
  localparam logic [31:0] TCM_MASK   = 32'hFFFF_0000;

  // Peripheral areas
  localparam logic [31:0] APB_BASE   = 32'h4000_0000;
  localparam logic [31:0] APB_MASK   = 32'hFFF8_0000;
  localparam logic [31:0] APB_HOLE   = 32'h0004_0000;
  localparam int          APB_SLOT_LSB = 12;
  localparam int          APB_SLOT_W   = 6;
  localparam logic [31:0] AHB_BASE   = 32'h4010_0000;
  localparam logic [31:0] AHB_END    = 32'h4016_0000;

  // Port checker granularity
  localparam int NRANGE    = 32;
  localparam int RANGE_LSB = 12;
  localparam int RULE_W    = 2 * NRANGE;
  localparam int NPORT     = 16;

  // Protection unit geometry
  localparam int         MPU_NRGN     = 8;
  localparam int         MPU_NSUB     = 8;
  localparam logic [4:0] MPU_MIN_LOG2 = 5'h08;
  localparam logic [4:0] MPU_SUB_BITS = 5'h03;

  typedef enum logic [3:0] {
    SAD_P_NONE  = 4'h0,
    SAD_P_RAM0  = 4'h1,
    SAD_P_RAM1  = 4'h2,
    SAD_P_RAM2  = 4'h3,
    SAD_P_RAM3  = 4'h4,
    SAD_P_RAM4  = 4'h5,
    SAD_P_RAM5  = 4'h6,
    SAD_P_ROM   = 4'h7,
    SAD_P_FLASH = 4'h8,
    SAD_P_TCM   = 4'h9,
    SAD_P_APB   = 4'hA,
    SAD_P_AHB   = 4'hB,
    SAD_P_DRAM  = 4'hC
  } sad_port_t;

  typedef enum logic [1:0] {
    SAD_RC_NS  = 2'h0,
    SAD_RC_S   = 2'h1,
    SAD_RC_NSC = 2'h2,
    SAD_RC_BLK = 2'h3
  } sad_rule_t;

endpackage

/* File: sad_port_checker.sv */
`timescale 1ns/1ps
module sad_port_checker #(
  parameter int NRANGE = 32
) (
  // Range table of the selected port
  input  wire logic [2*NRANGE-1:0]       i_rules,
  // Access attributes
  input  wire logic [$clog2(NRANGE)-1:0] i_range,
  input  wire logic                      i_secure,
  input  wire logic                      i_fetch,
  // Verdict
  output logic                           o_allow
);

  sad_pkg::sad_rule_t rule;

  always_comb
  begin
    rule = sad_pkg::sad_rule_t'(i_rules[2*i_range +: 2]);
    case (rule)
      sad_pkg::SAD_RC_NS:  o_allow = !i_secure;
      sad_pkg::SAD_RC_S:   o_allow = i_secure;
      // Non-secure code may only enter by fetching
      sad_pkg::SAD_RC_NSC: o_allow = i_secure | i_fetch;
      default:             o_allow = 1'b0;
    endcase
  end

endmodule

/* File: secure_alias_address_decoder_bench.sv */
`timescale 1ns/1ps
module secure_alias_address_decoder_bench;
  localparam logic [3:0] DN = 4'h1;
  localparam logic [3:0] ST = 4'h2;
  localparam logic [3:0] BE = 4'h4;
  localparam logic [3:0] MF = 4'h8;

  logic          i_core_clk;
  logic          i_resetn;
  logic [1023:0] chk_rules;
  logic          mpu_enable;
  logic [7:0]    mpu_rgn_en;
  logic [255:0]  mpu_base;
  logic [39:0]   mpu_size;
  logic [63:0]   mpu_sub_dis;
  logic [7:0]    mpu_ro;
  logic          cb_req, cb_write, cb_fetch, db_req, db_write;
  logic          dsp_req, dsp_write;
  logic [31:0]   cb_addr, db_addr, dsp_addr;
  logic          cb_done, cb_stall, cb_buserr, cb_mmfault, cb_secure;
  logic          db_done, db_stall, db_buserr, db_mmfault, db_secure;
  logic          dsp_done, dsp_stall, dsp_buserr;
  logic [3:0]    cb_port, db_port, dsp_port;
  logic [5:0]    db_slot;
  logic [16:0]   notes [$];
  logic [31:0]   lfsr_r;
  int            errors;
  int            checks_done;

  sad_bus_master_model sad_bus_master_model_inst (
    .i_core_clk(i_core_clk), .o_cb_req(cb_req), .o_cb_addr(cb_addr),
    .o_cb_write(cb_write), .o_cb_fetch(cb_fetch), .o_db_req(db_req),
    .o_db_addr(db_addr), .o_db_write(db_write), .o_dsp_req(dsp_req),
    .o_dsp_addr(dsp_addr), .o_dsp_write(dsp_write));

  sad_decoder sad_decoder_inst (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_cb_req(cb_req),
    .i_cb_addr(cb_addr), .i_cb_write(cb_write), .i_cb_fetch(cb_fetch),
    .i_db_req(db_req), .i_db_addr(db_addr), .i_db_write(db_write),
    .i_dsp_req(dsp_req), .i_dsp_addr(dsp_addr), .i_dsp_write(dsp_write),
    .i_chk_rules(chk_rules), .i_mpu_enable(mpu_enable),
    .i_mpu_rgn_en(mpu_rgn_en), .i_mpu_base(mpu_base),
    .i_mpu_size(mpu_size), .i_mpu_sub_dis(mpu_sub_dis), .i_mpu_ro(mpu_ro),
    .o_cb_done(cb_done), .o_cb_stall(cb_stall), .o_cb_buserr(cb_buserr),
    .o_cb_mmfault(cb_mmfault), .o_cb_port(cb_port), .o_cb_secure(cb_secure),
    .o_db_done(db_done), .o_db_stall(db_stall), .o_db_buserr(db_buserr),
    .o_db_mmfault(db_mmfault), .o_db_port(db_port), .o_db_secure(db_secure),
    .o_db_slot(db_slot), .o_dsp_done(dsp_done), .o_dsp_stall(dsp_stall),
    .o_dsp_buserr(dsp_buserr), .o_dsp_port(dsp_port));

  initial
  begin
    i_core_clk = 1'b0;
    forever #10 i_core_clk = ~i_core_clk;
  end

  task automatic results;
    $display("errors=%0d checks_done=%0d", errors, checks_done);
    if (errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check_resp(input logic [16:0] exp, input logic [16:0] got);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  // Note {master, slot, secure, port, flags}; fault answers skip the port
  task automatic req(input int m, input logic [31:0] a, input logic w,
                     input logic f, input logic [3:0] fl,
                     input logic [3:0] p);
    logic [5:0] s;
    logic       sec;
    s = (m == 1) ? a[17:12] : 6'h00;
    sec = (m == 2) ? 1'b0 : a[28];
    if (fl[3:2] != 2'h0)
      p = 4'h0;
    notes.push_back({m[1:0], s, sec, p, fl});
    sad_bus_master_model_inst.post(m, a, w, f);
  endtask

  function automatic logic [16:0] got_of(input int m);
    logic [3:0] fl;
    logic [3:0] p;
    logic [6:0] ss;
    fl = {1'b0, dsp_buserr, dsp_stall, dsp_done};
    p  = dsp_port;
    ss = 7'h00;
    if (m == 0)
    begin
      fl = {cb_mmfault, cb_buserr, cb_stall, cb_done};
      p  = cb_port;
      ss = {6'h00, cb_secure};
    end
    else if (m == 1)
    begin
      fl = {db_mmfault, db_buserr, db_stall, db_done};
      p  = db_port;
      ss = {db_slot, db_secure};
    end
    if (fl[3:2] != 2'h0)
      p = 4'h0;
    return {m[1:0], ss, p, fl};
  endfunction

  always @(negedge i_core_clk)
  begin
    if (i_resetn)
      for (int m = 0; m < 3; m++)
        if (got_of(m)[3:0] != 4'h0)
        begin
          if (notes.size() == 0)
            check_resp(17'h00000, got_of(m));
          else
            check_resp(notes.pop_front(), got_of(m));
        end
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {1'b0, v[31:1]} ^ (v[0] ? 32'h8020_0003 : 32'h0000_0000);
  endfunction

  initial
  begin
    #(20 * 3000);
    errors++;
    $display("ERROR t=%0t exp=%h got=%h", $time, 1'b0, 1'b1);
    results();
  end

  initial
  begin
    logic [5:0] sl;
    logic       sc;
    errors = 0;
    checks_done = 0;
    lfsr_r = 32'h8bd1;
    i_resetn = 1'b0;
    chk_rules = '0;
    // RAM ports: range 1 callable; APB: odd ranges secure only
    for (int p = 1; p < 7; p++)
      chk_rules[p*64+2 +: 2] = 2'h2;
    for (int r = 1; r < 32; r += 2)
      chk_rules[10*64+2*r +: 2] = 2'h1;
    {mpu_enable, mpu_rgn_en, mpu_ro} = 17'h00000;
    {mpu_base, mpu_size, mpu_sub_dis} = '0;
    repeat (12) @(negedge i_core_clk);
    i_resetn = 1'b1;
    @(posedge i_core_clk);
    req(0, 32'h0000_0000, 0, 1, DN, 4'h1);
    req(1, 32'h2001_0000, 0, 0, DN, 4'h2);
    req(2, 32'h0000_0040, 0, 0, DN, 4'hC);
    @(posedge i_core_clk);
    req(0, 32'h0000_0010, 0, 0, ST, 4'h1);
    req(1, 32'h2000_0020, 1, 0, DN, 4'h1);
    @(posedge i_core_clk);
    req(0, 32'h0000_1000, 0, 1, DN, 4'h1);
    req(1, 32'h2000_1000, 0, 0, BE, 4'h0);
    @(posedge i_core_clk);
    req(0, 32'h1000_1000, 0, 1, DN, 4'h1);
    req(1, 32'h3000_0000, 0, 0, BE, 4'h0);
    @(posedge i_core_clk);
    req(0, 32'h0300_0000, 0, 1, DN, 4'h7);
    req(1, 32'h2400_0000, 0, 0, DN, 4'h9);
    req(2, 32'h0200_0000, 0, 0, DN, 4'h0);
    @(posedge i_core_clk);
    req(0, 32'h0800_0000, 0, 1, DN, 4'h8);
    req(1, 32'h4010_0000, 0, 0, DN, 4'hB);
    req(2, 32'h0800_0000, 0, 0, ST, 4'h8);
    @(posedge i_core_clk);
    req(0, 32'h0200_0000, 0, 0, BE, 4'h0);
    req(1, 32'h4004_0000, 0, 0, BE, 4'h0);
    req(2, 32'h2800_0000, 1, 0, DN, 4'h8);
    for (int i = 0; i < 24; i++)
    begin
      @(posedge i_core_clk);
      lfsr_r = lfsr_next(lfsr_r);
      sl = lfsr_r[5:0];
      sc = lfsr_r[8];
      req(1, {3'h2, sc, 10'h000, sl, lfsr_r[19:10], 2'h0}, lfsr_r[9], 0,
          (sl[0] == sc) ? DN : BE, 4'hA);
    end
    repeat (3) @(posedge i_core_clk);
    @(negedge i_core_clk);
    mpu_enable = 1'b1;
    @(posedge i_core_clk);
    req(0, 32'h0000_0000, 0, 1, MF, 4'h0);
    req(1, 32'h2000_0000, 0, 0, MF, 4'h0);
    repeat (3) @(posedge i_core_clk);
    @(negedge i_core_clk);
    mpu_rgn_en = 8'h01;
    mpu_size[4:0] = 5'h1F;
    mpu_sub_dis = 64'h0000_0000_0000_0001;
    mpu_ro = 8'h01;
    @(posedge i_core_clk);
    req(0, 32'h0000_0000, 0, 1, MF, 4'h0);
    req(1, 32'h2000_0000, 0, 0, DN, 4'h1);
    @(posedge i_core_clk);
    req(1, 32'h2000_0004, 1, 0, MF, 4'h0);
    req(2, 32'h0000_0000, 1, 0, DN, 4'hC);
    @(posedge i_core_clk);
    req(0, 32'h0200_0000, 0, 0, MF, 4'h0);
    req(1, 32'h2100_0000, 0, 0, BE, 4'h0);
    repeat (4) @(posedge i_core_clk);
    check_resp(17'h00000, 17'(notes.size()));
    results();
  end
endmodule
